// ---- logic/setbit_branch_shift_subtract_exec.sv ----
// Decode and execute of bit set, short branch, one-bit shifts and subtract
`timescale 1ns/1ps
`default_nettype none
module setbit_branch_shift_subtract_exec
  import setbit_exec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic src_mode,
  input wire logic instr_valid,
  input wire logic [7:0] instr_byte,
  output logic instr_ready,
  output logic [15:0] pc,
  output flags_s flags,
  output bit_req_s bit_req,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  output logic mem_word,
  input wire logic mem_rd_valid,
  input wire logic [15:0] mem_rd_data,
  input wire logic reg_wr_en,
  input wire logic [4:0] reg_wr_sel,
  input wire logic [7:0] reg_wr_data,
  input wire logic [4:0] reg_rd_sel,
  output logic [7:0] reg_rd_data,
  output logic illegal,
  output logic done
);
  typedef struct packed {
    state_e state;
    logic prefix;
    logic ready;
    logic [7:0] op;
    logic [2:0][7:0] b;
    logic [1:0] idx;
    logic [2:0] need;
    logic [15:0] pc;
    regfile_t regs;
    flags_s flags;
    bit_req_s bit_req;
    logic mem_rd;
    logic [15:0] mem_addr;
    logic mem_word;
    logic [15:0] mem_data;
    logic [7:0] reg_rd_data;
    logic illegal;
    logic done;
  } core_s;

  core_s s_q;
  core_s s_d;

  // Register numbers scale with width: word j at byte 2j, dword k at byte 4k
  function automatic logic [31:0] rd_f(input regfile_t rf, input logic [3:0] r,
                                       input width_e w);
    logic [4:0] base;
    base = 5'(r);
    rd_f = 32'h0;
    unique case (w)
      W_BYTE: rd_f = {24'h0, rf[base]};
      W_WORD:
      begin
        base = {r, 1'b0};
        rd_f = {16'h0, rf[base], rf[base + 5'd1]};
      end
      W_DWORD:
      begin
        base = {r[2:0], 2'b00};
        rd_f = {rf[base], rf[base + 5'd1], rf[base + 5'd2], rf[base + 5'd3]};
      end
    endcase
  endfunction

  // High byte sits at the lower register index
  function automatic regfile_t wr_f(input regfile_t rf, input logic [3:0] r,
                                    input width_e w, input logic [31:0] v);
    logic [4:0] base;
    base = 5'(r);
    wr_f = rf;
    unique case (w)
      W_BYTE: wr_f[base] = v[7:0];
      W_WORD:
      begin
        base = {r, 1'b0};
        {wr_f[base], wr_f[base + 5'd1]} = v[15:0];
      end
      W_DWORD:
      begin
        base = {r[2:0], 2'b00};
        {wr_f[base], wr_f[base + 5'd1], wr_f[base + 5'd2], wr_f[base + 5'd3]} = v;
      end
    endcase
  endfunction

  // Operand bytes after the opcode; extended page only with escape or source mode
  function automatic logic [2:0] op_args_f(input logic [7:0] op, input logic pre,
                                           input logic ext_ok);
    op_args_f = ARGS_BAD;
    unique case (op)
      OPC_SHORT_BRANCH: op_args_f = pre ? ARGS_BAD : 3'd1;
      OPC_SET_CARRY: op_args_f = pre ? ARGS_BAD : 3'd0;
      OPC_SET_LEGACY: op_args_f = 3'd1;
      OPC_SET_EXT: op_args_f = ext_ok ? 3'd2 : ARGS_BAD;
      OPC_SHL, OPC_SAR, OPC_SHR_WORD: op_args_f = ext_ok ? 3'd1 : ARGS_BAD;
      OPC_SUB_BB, OPC_SUB_WW, OPC_SUB_DD: op_args_f = ext_ok ? 3'd1 : ARGS_BAD;
      OPC_SUB_EXT: op_args_f = ext_ok ? 3'd2 : ARGS_BAD;
      default: op_args_f = ARGS_BAD;
    endcase
  endfunction

  // The extended subtract page sizes itself from the low nibble
  function automatic logic [2:0] ext_args_f(input logic [3:0] nib);
    ext_args_f = ARGS_BAD;
    unique case (nib)
      NIB_BYTE, NIB_DIR8_B, NIB_DIR8_W, NIB_IND: ext_args_f = 3'd2;
      NIB_WORD, NIB_DWORD, NIB_DIR16_B, NIB_DIR16_W: ext_args_f = 3'd3;
      default: ext_args_f = ARGS_BAD;
    endcase
  endfunction

  function automatic logic mem_src_f(input logic [7:0] op, input logic [3:0] nib);
    mem_src_f = (op == OPC_SUB_EXT) && (nib == NIB_DIR8_B || nib == NIB_DIR8_W ||
                nib == NIB_DIR16_B || nib == NIB_DIR16_W || nib == NIB_IND);
  endfunction

  function automatic width_e sub_w_f(input logic [7:0] op, input logic [3:0] nib);
    sub_w_f = W_BYTE;
    if (op == OPC_SUB_WW)
    begin
      sub_w_f = W_WORD;
    end
    else if (op == OPC_SUB_DD)
    begin
      sub_w_f = W_DWORD;
    end
    else if (op == OPC_SUB_EXT)
    begin
      if (nib == NIB_WORD || nib == NIB_DIR8_W || nib == NIB_DIR16_W)
      begin
        sub_w_f = W_WORD;
      end
      else if (nib == NIB_DWORD)
      begin
        sub_w_f = W_DWORD;
      end
    end
  endfunction

  logic take;
  logic [3:0] nib;
  width_e sub_w;
  logic [3:0] dst_r;
  logic [31:0] ind_ptr;
  logic [31:0] sub_a;
  logic [31:0] sub_b;
  logic [31:0] sub_res;
  flags_s sub_fl;
  logic sh_word;
  shift_e sh_kind;
  logic [31:0] sh_src;
  logic [15:0] sh_res;
  logic sh_carry;
  logic sh_neg;
  logic sh_zero;

  assign take = instr_valid && s_q.ready;
  assign nib = s_q.b[0][3:0];

  // Operand selection for the subtractor; width follows the opcode, and the low nibble for OPC_SUB_EXT
  assign sub_w = sub_w_f(s_q.op, nib);
  assign dst_r = (s_q.op == OPC_SUB_EXT && nib == NIB_IND) ? s_q.b[1][7:4] : s_q.b[0][7:4];
  assign ind_ptr = rd_f(s_q.regs, s_q.b[0][7:4], W_WORD);
  assign sub_a = rd_f(s_q.regs, dst_r, sub_w);
  assign sub_b = (s_q.op != OPC_SUB_EXT) ? rd_f(s_q.regs, s_q.b[0][3:0], sub_w) :
                 (nib == NIB_BYTE) ? {24'h0, s_q.b[1]} :
                 (nib == NIB_WORD || nib == NIB_DWORD) ? {16'h0, s_q.b[1], s_q.b[2]} :
                 (sub_w == W_BYTE) ? {24'h0, s_q.mem_data[7:0]} : {16'h0, s_q.mem_data};

  sub_unit u_sub (
    .minuend(sub_a),
    .subtrahend(sub_b),
    .width(sub_w),
    .diff(sub_res),
    .fl(sub_fl)
  );

  // Shift kind from opcode; the prefixed d2 byte form shifts right logically
  assign sh_word = (nib == NIB_WORD);
  assign sh_kind = (s_q.op == OPC_SHL) ? SH_LEFT :
                   (s_q.op == OPC_SAR) ? SH_ARITH_RIGHT : SH_LOGIC_RIGHT;
  assign sh_src = rd_f(s_q.regs, s_q.b[0][7:4], sh_word ? W_WORD : W_BYTE);

  shift_unit u_shift (
    .value(sh_src[15:0]),
    .word(sh_word),
    .kind(sh_kind),
    .result(sh_res),
    .carry_out(sh_carry),
    .neg(sh_neg),
    .zero(sh_zero)
  );

  // Fetch, optional memory read, then one execute cycle per instruction
  always_comb
  begin
    logic [2:0] args;
    logic shift_ok;
    args = ARGS_BAD;
    shift_ok = 1'b0;
    s_d = s_q;
    s_d.bit_req.valid = 1'b0;
    s_d.illegal = 1'b0;
    s_d.done = 1'b0;
    s_d.reg_rd_data = s_q.regs[reg_rd_sel];
    if (reg_wr_en)
    begin
      s_d.regs[reg_wr_sel] = reg_wr_data;
    end
    unique case (s_q.state)
      ST_OP:
      begin
        if (take)
        begin
          s_d.pc = s_q.pc + PC_STEP;
          s_d.op = instr_byte;
          s_d.idx = 2'd0;
          if (instr_byte == OPC_PREFIX && !s_q.prefix)
          begin
            s_d.prefix = 1'b1;
          end
          else
          begin
            args = op_args_f(instr_byte, s_q.prefix, s_q.prefix || src_mode);
            s_d.need = args;
            if (args == ARGS_BAD)
            begin
              s_d.illegal = 1'b1;
              s_d.prefix = 1'b0;
            end
            else
            begin
              s_d.state = (args == 3'd0) ? ST_EXEC : ST_ARGS;
            end
          end
        end
      end
      ST_ARGS:
      begin
        if (take)
        begin
          s_d.pc = s_q.pc + PC_STEP;
          s_d.b[s_q.idx] = instr_byte;
          s_d.idx = s_q.idx + 2'd1;
          args = s_q.need;
          if (s_q.op == OPC_SUB_EXT && s_q.idx == 2'd0)
          begin
            args = ext_args_f(instr_byte[3:0]);
          end
          s_d.need = args;
          if (args == ARGS_BAD)
          begin
            s_d.illegal = 1'b1;
            s_d.prefix = 1'b0;
            s_d.state = ST_OP;
          end
          else if ({1'b0, s_q.idx} + 3'd1 == args)
          begin
            s_d.state = mem_src_f(s_q.op, s_d.b[0][3:0]) ? ST_MEM : ST_EXEC;
          end
        end
      end
      ST_MEM:
      begin
        if (!s_q.mem_rd)
        begin
          s_d.mem_rd = 1'b1;
          s_d.mem_word = (sub_w == W_WORD);
          if (nib == NIB_DIR8_B || nib == NIB_DIR8_W)
          begin
            s_d.mem_addr = {8'h00, s_q.b[1]};
          end
          else if (nib == NIB_IND)
          begin
            s_d.mem_addr = ind_ptr[15:0];
          end
          else
          begin
            s_d.mem_addr = {s_q.b[1], s_q.b[2]};
          end
        end
        else if (mem_rd_valid)
        begin
          s_d.mem_rd = 1'b0;
          s_d.mem_data = mem_rd_data;
          s_d.state = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        s_d.state = ST_OP;
        s_d.prefix = 1'b0;
        unique case (s_q.op)
          OPC_SHORT_BRANCH:
          begin
            // Pc already counted both bytes, so only the displacement remains
            s_d.pc = s_q.pc + {{8{s_q.b[0][7]}}, s_q.b[0]};
          end
          OPC_SET_LEGACY:
          begin
            if (s_q.prefix)
            begin
              shift_ok = (nib == NIB_BYTE);
            end
            else
            begin
              s_d.bit_req = {1'b1, 1'b0, 3'd0, s_q.b[0]};
            end
          end
          OPC_SET_CARRY:
          begin
            s_d.flags.borrow_carry_flag = 1'b1;
          end
          OPC_SET_EXT:
          begin
            if (s_q.b[0][7:4] == EXT_SET_HI && !s_q.b[0][3])
            begin
              s_d.bit_req = {1'b1, 1'b1, s_q.b[0][2:0], s_q.b[1]};
            end
            else
            begin
              s_d.illegal = 1'b1;
            end
          end
          OPC_SHL, OPC_SAR:
          begin
            shift_ok = (nib == NIB_BYTE) || (nib == NIB_WORD);
          end
          OPC_SHR_WORD:
          begin
            shift_ok = (nib == NIB_WORD);
          end
          OPC_SUB_BB, OPC_SUB_WW, OPC_SUB_DD, OPC_SUB_EXT:
          begin
            s_d.regs = wr_f(s_d.regs, dst_r, sub_w, sub_res);
            s_d.flags.borrow_carry_flag = sub_fl.borrow_carry_flag;
            s_d.flags.signed_wrap_flag = sub_fl.signed_wrap_flag;
            s_d.flags.neg = sub_fl.neg;
            s_d.flags.zero = sub_fl.zero;
            if (sub_w == W_BYTE)
            begin
              s_d.flags.half_borrow_flag = sub_fl.half_borrow_flag;
            end
          end
          default:
          begin
            s_d.illegal = 1'b1;
          end
        endcase
        // Shifts leave half borrow and overflow alone
        if (shift_ok)
        begin
          s_d.regs = wr_f(s_d.regs, s_q.b[0][7:4], sh_word ? W_WORD : W_BYTE,
                          {16'h0, sh_res});
          s_d.flags.borrow_carry_flag = sh_carry;
          s_d.flags.neg = sh_neg;
          s_d.flags.zero = sh_zero;
        end
        else if (s_q.op == OPC_SHL || s_q.op == OPC_SAR || s_q.op == OPC_SHR_WORD ||
                 (s_q.op == OPC_SHR_BYTE && s_q.prefix))
        begin
          s_d.illegal = 1'b1;
        end
        s_d.done = !s_d.illegal;
      end
    endcase
    // Ready is registered, so it tracks the state being entered
    s_d.ready = (s_d.state == ST_OP) || (s_d.state == ST_ARGS);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_q <= '{state: ST_OP, prefix: 1'b0, ready: 1'b1, op: 8'h00, b: '0, idx: 2'd0,
               need: 3'd0, pc: PC_RESET, regs: REGS_RESET, flags: FLAGS_RESET,
               bit_req: BIT_REQ_RESET, mem_rd: 1'b0, mem_addr: 16'h0000,
               mem_word: 1'b0, mem_data: 16'h0000, reg_rd_data: 8'h00,
               illegal: 1'b0, done: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // All outputs come straight from the state register
  assign instr_ready = s_q.ready;
  assign pc = s_q.pc;
  assign flags = s_q.flags;
  assign bit_req = s_q.bit_req;
  assign mem_rd = s_q.mem_rd;
  assign mem_addr = s_q.mem_addr;
  assign mem_word = s_q.mem_word;
  assign reg_rd_data = s_q.reg_rd_data;
  assign illegal = s_q.illegal;
  assign done = s_q.done;
endmodule
`default_nettype wire

// ---- logic/setbit_exec_pkg.sv ----
// Shared opcodes, field codes, types and reset values for the execute slice
package setbit_exec_pkg;
  // Escape byte that opens the extended opcode page in binary mode
  localparam logic [7:0] OPC_PREFIX = 8'ha5;
  localparam logic [7:0] OPC_SHORT_BRANCH = 8'h80;
  localparam logic [7:0] OPC_SET_LEGACY = 8'hd2;
  localparam logic [7:0] OPC_SHR_BYTE = 8'hd2;
  localparam logic [7:0] OPC_SET_CARRY = 8'hd3;
  localparam logic [7:0] OPC_SET_EXT = 8'ha9;
  localparam logic [7:0] OPC_SHL = 8'h3e;
  localparam logic [7:0] OPC_SAR = 8'h0e;
  localparam logic [7:0] OPC_SHR_WORD = 8'h1e;
  localparam logic [7:0] OPC_SUB_BB = 8'h9c;
  localparam logic [7:0] OPC_SUB_WW = 8'h9d;
  localparam logic [7:0] OPC_SUB_DD = 8'h9f;
  localparam logic [7:0] OPC_SUB_EXT = 8'h9e;
  // High nibble of the second byte of the extended bit set
  localparam logic [3:0] EXT_SET_HI = 4'hd;
  // Low nibble codes of the second byte
  localparam logic [3:0] NIB_BYTE = 4'h0;
  localparam logic [3:0] NIB_WORD = 4'h4;
  localparam logic [3:0] NIB_DWORD = 4'h8;
  localparam logic [3:0] NIB_DIR8_B = 4'h1;
  localparam logic [3:0] NIB_DIR8_W = 4'h5;
  localparam logic [3:0] NIB_DIR16_B = 4'h3;
  localparam logic [3:0] NIB_DIR16_W = 4'h7;
  localparam logic [3:0] NIB_IND = 4'h9;
  // Operand byte count marking an opcode that is not handled here
  localparam logic [2:0] ARGS_BAD = 3'h7;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;

  typedef enum logic [1:0] {W_BYTE, W_WORD, W_DWORD} width_e;
  typedef enum logic [1:0] {SH_LEFT, SH_ARITH_RIGHT, SH_LOGIC_RIGHT} shift_e;
  typedef enum logic [1:0] {ST_OP, ST_ARGS, ST_MEM, ST_EXEC} state_e;

  typedef struct packed {
    logic borrow_carry_flag;
    logic half_borrow_flag;
    logic signed_wrap_flag;
    logic neg;
    logic zero;
  } flags_s;

  typedef struct packed {
    logic valid;
    logic extended;
    logic [2:0] index;
    logic [7:0] addr;
  } bit_req_s;

  typedef logic [31:0][7:0] regfile_t;

  localparam flags_s FLAGS_RESET = '0;
  localparam bit_req_s BIT_REQ_RESET = '0;
  localparam regfile_t REGS_RESET = '0;
endpackage

// ---- logic/sub_unit.sv ----
// Byte, word and dword subtractor with borrow, half borrow and signed overflow
`timescale 1ns/1ps
`default_nettype none
module sub_unit
  import setbit_exec_pkg::*;
(
  input wire logic [31:0] minuend,
  input wire logic [31:0] subtrahend,
  input var width_e width,
  output logic [31:0] diff,
  output flags_s fl
);
  logic [4:0] d4;
  logic [8:0] d8;
  logic [16:0] d16;
  logic [32:0] d32;
  logic sa;
  logic sb;
  logic sr;

  // One extra bit on each width catches the borrow out of the top byte
  always_comb
  begin
    diff = '0;
    fl = '0;
    sa = 1'b0;
    sb = 1'b0;
    sr = 1'b0;
    d4 = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    d8 = {1'b0, minuend[7:0]} - {1'b0, subtrahend[7:0]};
    d16 = {1'b0, minuend[15:0]} - {1'b0, subtrahend[15:0]};
    d32 = {1'b0, minuend} - {1'b0, subtrahend};
    unique case (width)
      W_BYTE:
      begin
        diff = {24'h0, d8[7:0]};
        fl.borrow_carry_flag = d8[8];
        {sa, sb, sr} = {minuend[7], subtrahend[7], d8[7]};
      end
      W_WORD:
      begin
        diff = {16'h0, d16[15:0]};
        fl.borrow_carry_flag = d16[16];
        {sa, sb, sr} = {minuend[15], subtrahend[15], d16[15]};
      end
      W_DWORD:
      begin
        diff = d32[31:0];
        fl.borrow_carry_flag = d32[32];
        {sa, sb, sr} = {minuend[31], subtrahend[31], d32[31]};
      end
    endcase
    fl.half_borrow_flag = d4[4];
    // Overflow only when the operand signs differ and the result left the minuend sign
    fl.signed_wrap_flag = (sa ^ sb) & (sr ^ sa);
    fl.neg = sr;
    fl.zero = (diff == 32'h0);
  end
endmodule
`default_nettype wire

// ---- logic/shift_unit.sv ----
// One-position shifter for byte and word operands
`timescale 1ns/1ps
`default_nettype none
module shift_unit
  import setbit_exec_pkg::*;
(
  input wire logic [15:0] value,
  input wire logic word,
  input var shift_e kind,
  output logic [15:0] result,
  output logic carry_out,
  output logic neg,
  output logic zero
);
  // Byte forms keep the upper byte at zero so the writer can take the low half
  always_comb
  begin
    result = '0;
    carry_out = 1'b0;
    unique case (kind)
      SH_LEFT:
      begin
        result = word ? {value[14:0], 1'b0} : {8'h0, value[6:0], 1'b0};
        carry_out = word ? value[15] : value[7];
      end
      SH_ARITH_RIGHT:
      begin
        result = word ? {value[15], value[15:1]} : {8'h0, value[7], value[7:1]};
        carry_out = value[0];
      end
      SH_LOGIC_RIGHT:
      begin
        result = word ? {1'b0, value[15:1]} : {8'h0, 1'b0, value[7:1]};
        carry_out = value[0];
      end
    endcase
    neg = word ? result[15] : result[7];
    zero = word ? (result == 16'h0) : (result[7:0] == 8'h0);
  end
endmodule
`default_nettype wire

// ---- verification/setbit_exec_chk.sv ----
// Port-level assertions for the execute slice
`timescale 1ns/1ps
`default_nettype none
module setbit_exec_chk
  import setbit_exec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [15:0] pc,
  input var flags_s flags,
  input var bit_req_s bit_req,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic mem_word,
  input wire logic mem_rd_valid,
  input wire logic done
);
  // Single clock domain, so clock and reset are stated once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Fetch side: every byte taken moves the counter by one
  property p_pc_step;
    instr_valid && instr_ready |=> pc == $past(pc) + PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
  // Flags move only in a completing cycle; reset tail excluded
  property p_flags_hold;
    $changed(flags) && !$past(sys_rst) |-> done;
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags moved");
  property p_bit_set;
    bit_req.valid |-> $stable(flags) ##1 !bit_req.valid;
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set pulse or flags");
  // Memory handshake: request held steady, then dropped and finished
  property p_mem_hold;
    mem_rd && !mem_rd_valid |=> mem_rd && $stable(mem_addr) && $stable(mem_word);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("read request moved");
  property p_mem_end;
    mem_rd && mem_rd_valid |=> !mem_rd ##1 done;
  endproperty
  a_mem_end: assert property (p_mem_end) else $error("read not closed");
  property p_mem_busy;
    mem_rd |-> !instr_ready;
  endproperty
  a_mem_busy: assert property (p_mem_busy) else $error("ready during read");
  // Completion only follows a refused cycle and lasts one cycle
  property p_done_cause;
    done |-> !$past(instr_ready);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done unprompted");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  c_done: cover property (done);
  c_bit: cover property (bit_req.valid);
  c_mem: cover property (mem_rd && mem_rd_valid);
endmodule
bind setbit_branch_shift_subtract_exec setbit_exec_chk chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .pc(pc), .flags(flags), .bit_req(bit_req),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_word(mem_word),
  .mem_rd_valid(mem_rd_valid), .done(done)
);
`default_nettype wire

// ---- verification/setbit_branch_shift_subtract_exec_bench.sv ----
// Self-checking bench for bit set, short branch, shifts and subtract
`timescale 1ns/1ps
`default_nettype none
module setbit_branch_shift_subtract_exec_bench
  import setbit_exec_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic src_mode = 1'b0;
  logic instr_valid = 1'b0;
  logic [7:0] instr_byte = 8'h00;
  logic mem_rd_valid = 1'b0;
  logic [15:0] mem_rd_data = 16'h0000;
  logic reg_wr_en = 1'b0;
  logic [4:0] reg_wr_sel = 5'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic [4:0] reg_rd_sel = 5'h00;
  logic instr_ready, mem_rd, mem_word, illegal, done;
  logic [15:0] pc, mem_addr;
  logic [15:0] maddr = 16'h0000;
  logic [15:0] mem_val = 16'h0000;
  logic [15:0] p = 16'h0000;
  logic [7:0] reg_rd_data;
  flags_s flags;
  bit_req_s bit_req;
  bit_req_s br = '0;
  logic mseen = 1'b0;
  logic mword = 1'b0;
  int mismatches = 0;
  int checks = 0;
  int n_done = 0;
  int n_ill = 0;

  setbit_branch_shift_subtract_exec dut_u (
    .clk_sys, .sys_rst, .src_mode, .instr_valid, .instr_byte, .instr_ready,
    .pc, .flags, .bit_req, .mem_rd, .mem_addr, .mem_word, .mem_rd_valid,
    .mem_rd_data, .reg_wr_en, .reg_wr_sel, .reg_wr_data, .reg_rd_sel,
    .reg_rd_data, .illegal, .done
  );

  always #5 clk_sys = ~clk_sys;

  // Pulses are sampled mid-cycle so edge ordering cannot hide them
  always @(negedge clk_sys)
  begin
    if (done === 1'b1) n_done++;
    if (illegal === 1'b1) n_ill++;
    if (bit_req.valid === 1'b1) br = bit_req;
    mseen = (mem_rd === 1'b1);
    if (mseen) {mword, maddr} = {mem_word, mem_addr};
  end

  // Memory answers one cycle after it sees a request, for one cycle
  always @(posedge clk_sys)
  begin
    mem_rd_valid <= mseen && !mem_rd_valid;
    mem_rd_data <= mem_val;
  end

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_fl(input flags_s e);
    chk({27'h0, flags}, {27'h0, e});
  endtask

  // Register byte read back; data shows one cycle after the select
  task automatic chk_reg(input logic [4:0] s, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd_sel <= s;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({24'h0, reg_rd_data}, {24'h0, e});
  endtask

  task automatic setreg(input logic [4:0] s, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_wr_sel <= s;
    reg_wr_data <= v;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask

  task automatic mode(input logic m);
    @(posedge clk_sys);
    src_mode <= m;
  endtask

  // Offers one byte and returns at the edge that takes it
  task automatic put(input logic [7:0] b);
    int k;
    k = 0;
    instr_valid <= 1'b1;
    instr_byte <= b;
    @(negedge clk_sys);
    while (instr_ready !== 1'b1 && k < 40)
    begin
      @(negedge clk_sys);
      k++;
    end
    @(posedge clk_sys);
  endtask

  // Sends a whole instruction, then expects either done or illegal
  task automatic exec(input logic [7:0] q[$], input logic ill);
    int d0, i0, k;
    d0 = n_done;
    i0 = n_ill;
    k = 0;
    br = '0;
    @(negedge clk_sys);
    p = pc;
    @(posedge clk_sys);
    foreach (q[i]) put(q[i]);
    instr_valid <= 1'b0;
    while (n_done == d0 && n_ill == i0 && k < 40)
    begin
      @(negedge clk_sys);
      k++;
    end
    chk({30'h0, n_ill != i0, n_done != d0}, {30'h0, ill, !ill});
  endtask

  task automatic shf(input logic [7:0] o, input logic [7:0] r, input logic [4:0] s,
    input logic [7:0] e, input flags_s f);
    exec('{8'ha5, o, r}, 1'b0);
    chk_reg(s, e);
    chk_fl(f);
  endtask

  task automatic t_sub_reg;
    setreg(5'h01, 8'hc9);
    setreg(5'h00, 8'h54);
    exec('{8'ha5, 8'h9c, 8'h10}, 1'b0);
    chk_reg(5'h01, 8'h75);
    chk_fl(5'h04);
    chk({16'h0, pc}, {16'h0, p + 16'h0003});
    exec('{8'h9c}, 1'b1);
    mode(1'b1);
    setreg(5'h03, 8'h10);
    setreg(5'h02, 8'h20);
    exec('{8'h9c, 8'h32}, 1'b0);
    chk_reg(5'h03, 8'hf0);
    chk_fl(5'h12);
    mode(1'b0);
  endtask

  // Half borrow must survive the word and dword forms
  task automatic t_sub_wide;
    setreg(5'h04, 8'h10);
    setreg(5'h05, 8'h01);
    exec('{8'ha5, 8'h9c, 8'h45}, 1'b0);
    chk_fl(5'h08);
    setreg(5'h08, 8'h80);
    setreg(5'h0b, 8'h01);
    exec('{8'ha5, 8'h9d, 8'h45}, 1'b0);
    chk_reg(5'h08, 8'h7f);
    chk_fl(5'h0c);
    setreg(5'h13, 8'h01);
    exec('{8'ha5, 8'h9f, 8'h34}, 1'b0);
    chk_reg(5'h0c, 8'hff);
    chk_fl(5'h1a);
  endtask

  task automatic t_sub_imm;
    setreg(5'h06, 8'h05);
    exec('{8'ha5, 8'h9e, 8'h60, 8'h05}, 1'b0);
    chk_fl(5'h01);
    exec('{8'ha5, 8'h9e, 8'h74, 8'h12, 8'h34}, 1'b0);
    chk_reg(5'h0e, 8'hed);
    chk_fl(5'h02);
    exec('{8'ha5, 8'h9e, 8'h08, 8'h00, 8'h01}, 1'b0);
    chk_reg(5'h03, 8'hef);
    chk_fl(5'h00);
  endtask

  task automatic t_sub_mem;
    mem_val = 16'h0030;
    exec('{8'ha5, 8'h9e, 8'h21, 8'haa}, 1'b0);
    chk({15'h0, mword, maddr}, 32'h000000aa);
    chk_reg(5'h02, 8'hf0);
    mem_val = 16'h0001;
    exec('{8'ha5, 8'h9e, 8'h57, 8'h12, 8'h34}, 1'b0);
    chk({15'h0, mword, maddr}, 32'h00011234);
    chk_fl(5'h01);
    mem_val = 16'h0010;
    exec('{8'ha5, 8'h9e, 8'h49, 8'h30}, 1'b0);
    chk({15'h0, mword, maddr}, 32'h00007fff);
    chk_reg(5'h03, 8'hdf);
    // Byte destination through a 16-bit address, then word through an 8-bit one
    mem_val = 16'h00e0;
    exec('{8'ha5, 8'h9e, 8'h43, 8'h56, 8'h78}, 1'b0);
    chk({15'h0, mword, maddr}, 32'h00005678);
    chk_reg(5'h04, 8'h2f);
    chk_fl(5'h10);
    mem_val = 16'h0102;
    exec('{8'ha5, 8'h9e, 8'h65, 8'h5c}, 1'b0);
    chk({15'h0, mword, maddr}, 32'h0001005c);
    chk_reg(5'h0c, 8'hfe);
    chk_fl(5'h02);
  endtask

  task automatic t_bitset;
    exec('{8'hd2, 8'h33}, 1'b0);
    chk({19'h0, br}, {19'h0, 13'h1033});
    chk_fl(5'h02);
    exec('{8'ha5, 8'ha9, 8'hd5, 8'h44}, 1'b0);
    chk({19'h0, br}, {19'h0, 13'h1d44});
    exec('{8'hd3}, 1'b0);
    chk_fl(5'h12);
    exec('{8'ha5, 8'hd3}, 1'b1);
    exec('{8'ha9}, 1'b1);
    exec('{8'ha5, 8'ha5}, 1'b1);
  endtask

  task automatic t_shift;
    shf(8'h3e, 8'h10, 5'h01, 8'hea, 5'h02);
    shf(8'h0e, 8'h10, 5'h01, 8'hf5, 5'h02);
    shf(8'hd2, 8'h10, 5'h01, 8'h7a, 5'h10);
    shf(8'h3e, 8'h44, 5'h08, 8'hff, 5'h02);
    shf(8'h0e, 8'h44, 5'h08, 8'hff, 5'h02);
    shf(8'h1e, 8'h44, 5'h08, 8'h7f, 5'h10);
    exec('{8'ha5, 8'h3e, 8'h12}, 1'b1);
    // Source mode takes the extended page without the escape byte
    mode(1'b1);
    exec('{8'h1e, 8'h44}, 1'b0);
    chk_reg(5'h08, 8'h3f);
    chk_fl(5'h10);
    mode(1'b0);
  endtask

  task automatic t_branch;
    exec('{8'h80, 8'h21}, 1'b0);
    chk({16'h0, pc}, {16'h0, p + 16'h0023});
    exec('{8'h80, 8'hfe}, 1'b0);
    chk({16'h0, pc}, {16'h0, p});
    exec('{8'h80, 8'h80}, 1'b0);
    chk({16'h0, pc}, {16'h0, p - 16'h007e});
    chk_fl(5'h10);
  endtask

  // Main sequence; each scenario leaves state the next one builds on
  initial
  begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    chk({15'h0, instr_ready, pc}, 32'h00010000);
    t_sub_reg;
    t_sub_wide;
    t_sub_imm;
    t_sub_mem;
    t_bitset;
    t_shift;
    t_branch;
    finish_test;
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
